// ### design/low_voltage_warning_regs.sv
/*
 * Low-voltage warning status and control register with its interrupt logic,
 * behind a classic Wishbone slave.
 * Assumes rst_b is the power-on reset, chip_reset and deep_stop_recovery come
 * from the reset controller on clk, and supply_below_warn is an asynchronous
 * comparator level from the analog supply monitor.
 */
// Implementation choice: the Wishbone register port.
module low_voltage_warning_regs (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        chip_reset,
    input  wire logic                        deep_stop_recovery,
    input  wire logic                        low_power_mode,
    input  wire logic                        supply_below_warn,
    input  wire logic [warn_pkg::TRIP_W-1:0] detect_trip_select,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [warn_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [warn_pkg::SEL_W-1:0]  wb_sel_i,
    input  wire logic [warn_pkg::DAT_W-1:0]  wb_dat_i,
    input  wire logic                        wb_tga_i,
    output logic      [warn_pkg::DAT_W-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    output logic                             wb_err_o,
    output logic      [warn_pkg::TRIP_W-1:0] warn_trip_select,
    output logic      [warn_pkg::TRIP_W:0]   warn_threshold,
    output logic                             monitor_enable,
    output logic                             warn_irq,
    output logic                             irq
);
    import warn_pkg::*;

    reg_access_if acc ();

    logic                below_s;
    logic                below_prev_q;
    logic                warn_event;
    logic                soft_reset;
    logic                wr_ok;
    logic                wr_blocked;
    logic                wr_warn;
    logic                warn_event_flag_q;
    logic                warn_irq_enable_q;
    logic [TRIP_W-1:0]   trip_q;
    logic [EVT_W-1:0]    evt_status_q;
    logic [EVT_W-1:0]    evt_enable_q;
    logic [EVT_W-1:0]    evt_set;
    logic [EVT_W-1:0]    evt_clr;
    logic [REG_W-1:0]    warn_reg_rd;

    wb_front u_front (
        .clk      (clk),
        .rst_b    (rst_b),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_tga_i (wb_tga_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .wb_err_o (wb_err_o),
        .acc      (acc)
    );

    sync_2ff #(.W(1)) u_below_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (supply_below_warn),
        .sync_out (below_s)
    );

    // Chip reset that is not a deep-stop recovery
    assign soft_reset = chip_reset & ~deep_stop_recovery;

    // Monitor is off in low-power modes whatever the register says
    assign monitor_enable = ~low_power_mode;

    // Previous sample starts at zero after power-on reset and soft_reset, so a supply that is
    // already low when reset ends still produces one event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            below_prev_q <= 1'b0;
        end else if (soft_reset || low_power_mode) begin
            below_prev_q <= 1'b0;
        end else begin
            below_prev_q <= below_s;
        end
    end

    assign warn_event = below_s & ~below_prev_q & ~low_power_mode;

    // User-mode writes are refused with err and only set the privilege event status bit
    assign acc.refuse = acc.we & ~acc.supervisor;
    assign wr_ok      = acc.req & acc.we & acc.supervisor;
    assign wr_blocked = acc.req & acc.refuse;
    assign wr_warn    = wr_ok & (acc.idx == WARN_IDX) & acc.sel[0];

    // Flag: only hardware sets it, the acknowledge bit clears it, set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_event_flag_q <= FLAG_RST;
        end else if (soft_reset) begin
            warn_event_flag_q <= FLAG_RST;
        end else if (warn_event) begin
            warn_event_flag_q <= 1'b1;
        end else if (wr_warn && acc.wdata[ACK_BIT]) begin
            warn_event_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_irq_enable_q <= IE_RST;
        end else if (soft_reset) begin
            warn_irq_enable_q <= IE_RST;
        end else if (wr_warn) begin
            warn_irq_enable_q <= acc.wdata[IE_BIT];
        end
    end

    // Trip select survives every reset except power-on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trip_q <= TRIP_RST;
        end else if (wr_warn) begin
            trip_q <= acc.wdata[SEL_LSB +: TRIP_W];
        end
    end

    assign warn_trip_select = trip_q;
    // Detect select codes above one are reserved, so its low bit suffices
    assign warn_threshold   = {detect_trip_select[0], trip_q};
    assign warn_irq         = warn_event_flag_q & warn_irq_enable_q;

    // Sticky event status for the summary interrupt
    assign evt_set[EVT_WARN] = warn_event;
    assign evt_set[EVT_PRIV] = wr_blocked;
    assign evt_clr = (wr_ok && acc.idx == IRQ_CLR_IDX && acc.sel[0])
                     ? acc.wdata[EVT_W-1:0] : '0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_status_q <= EVT_RST;
        end else if (soft_reset) begin
            evt_status_q <= EVT_RST;
        end else begin
            evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_enable_q <= EVT_RST;
        end else if (soft_reset) begin
            evt_enable_q <= EVT_RST;
        end else if (wr_ok && acc.idx == IRQ_EN_IDX && acc.sel[0]) begin
            evt_enable_q <= acc.wdata[EVT_W-1:0];
        end
    end

    assign irq = |(evt_status_q & evt_enable_q);

    // Acknowledge and reserved bits always read as zero
    always_comb begin
        warn_reg_rd            = '0;
        warn_reg_rd[FLAG_BIT]  = warn_event_flag_q;
        warn_reg_rd[IE_BIT]    = warn_irq_enable_q;
        warn_reg_rd[SEL_LSB +: TRIP_W] = trip_q;
    end

    always_comb begin
        acc.rdata = '0;
        case (acc.idx)
            WARN_IDX:     acc.rdata[REG_W-1:0] = warn_reg_rd;
            IRQ_STAT_IDX: acc.rdata[EVT_W-1:0] = evt_status_q;
            IRQ_EN_IDX:   acc.rdata[EVT_W-1:0] = evt_enable_q;
            default:      acc.rdata = '0;
        endcase
    end
endmodule

// ### design/warn_pkg.sv
/*
 * Constants for the low-voltage warning register block: register map,
 * field positions, reset values and widths.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package warn_pkg;
    // Bus geometry
    localparam int         ADR_W          = 8;
    localparam int         IDX_W          = ADR_W - 2;
    localparam int         DAT_W          = 32;
    localparam int         SEL_W          = DAT_W / 8;

    // Word indices; byte address is four times the index
    localparam logic [IDX_W-1:0] WARN_IDX     = 6'h01;
    localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 6'h02;
    localparam logic [IDX_W-1:0] IRQ_CLR_IDX  = 6'h03;
    localparam logic [IDX_W-1:0] IRQ_EN_IDX   = 6'h04;

    // Warning register fields
    localparam int         FLAG_BIT       = 7;
    localparam int         ACK_BIT        = 6;
    localparam int         IE_BIT         = 5;
    localparam int         SEL_LSB        = 0;
    localparam int         TRIP_W         = 2;
    localparam int         REG_W          = 8;

    // Reset values
    localparam logic              FLAG_RST  = 1'b0;
    localparam logic              IE_RST    = 1'b0;
    localparam logic [TRIP_W-1:0] TRIP_RST  = 2'h0;

    // Interrupt status layout
    localparam int         EVT_W          = 2;
    localparam int         EVT_WARN       = 0;
    localparam int         EVT_PRIV       = 1;
    localparam logic [EVT_W-1:0] EVT_RST  = 2'h0;
endpackage

// ### design/reg_access_if.sv
/*
 * Decoded register access passed from the bus front end to the register bank.
 * Assumes both ends share one clock.
 */
interface reg_access_if;
    import warn_pkg::*;
    logic                req;
    logic                we;
    logic                supervisor;
    logic [IDX_W-1:0]    idx;
    logic [SEL_W-1:0]    sel;
    logic [DAT_W-1:0]    wdata;
    logic [DAT_W-1:0]    rdata;
    logic                refuse;

    modport front (output req, we, supervisor, idx, sel, wdata, input rdata, refuse);
    modport bank  (input req, we, supervisor, idx, sel, wdata, output rdata, refuse);
endinterface

// ### design/sync_2ff.sv
/*
 * Two-flop synchroniser for levels arriving from outside the clock domain.
 * Assumes the source level is stable for at least two clock cycles.
 */
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### design/wb_front.sv
/*
 * Classic Wishbone slave front end: turns a bus cycle into one request pulse
 * and answers with ack or err one cycle later.
 * Assumes the master holds its request until it sees ack or err.
 */
module wb_front (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [warn_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [warn_pkg::SEL_W-1:0] wb_sel_i,
    input  wire logic [warn_pkg::DAT_W-1:0] wb_dat_i,
    input  wire logic                       wb_tga_i,
    output logic      [warn_pkg::DAT_W-1:0] wb_dat_o,
    output logic                            wb_ack_o,
    output logic                            wb_err_o,
    reg_access_if.front                     acc
);
    import warn_pkg::*;

    // Answer flops block a second request while the master still holds stb
    assign acc.req        = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign acc.we         = wb_we_i;
    assign acc.supervisor = wb_tga_i;
    assign acc.idx        = wb_adr_i[ADR_W-1:2];
    assign acc.sel        = wb_sel_i;
    assign acc.wdata      = wb_dat_i;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= acc.req & ~acc.refuse;
            wb_err_o <= acc.req & acc.refuse;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= '0;
        end else if (acc.req) begin
            wb_dat_o <= acc.we ? '0 : acc.rdata;
        end
    end
endmodule

// ### verification/low_voltage_warning_regs_assertions.sv
/* Checker for the warning register block: bus answer timing, field read-back,
   threshold and monitor outputs.
   Assumes it is bound to the block and sees only its ports. */
module warn_checker (
    input wire logic                        clk,
    input wire logic                        rst_b,
    input wire logic                        chip_reset,
    input wire logic                        deep_stop_recovery,
    input wire logic                        low_power_mode,
    input wire logic [warn_pkg::TRIP_W-1:0] detect_trip_select,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_we_i,
    input wire logic [warn_pkg::ADR_W-1:0]  wb_adr_i,
    input wire logic [warn_pkg::SEL_W-1:0]  wb_sel_i,
    input wire logic [warn_pkg::DAT_W-1:0]  wb_dat_i,
    input wire logic                        wb_tga_i,
    input wire logic [warn_pkg::DAT_W-1:0]  wb_dat_o,
    input wire logic                        wb_ack_o,
    input wire logic                        wb_err_o,
    input wire logic [warn_pkg::TRIP_W-1:0] warn_trip_select,
    input wire logic [warn_pkg::TRIP_W:0]   warn_threshold,
    input wire logic                        monitor_enable,
    input wire logic                        warn_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import warn_pkg::*;
    logic taken;
    logic warn_rd;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign warn_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == WARN_IDX;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sup_answer_a: assert property (taken && !(wb_we_i && !wb_tga_i)
        |=> wb_ack_o && !wb_err_o)
        else $error("supervisor access not acked next cycle");
    user_err_a: assert property (taken && wb_we_i && !wb_tga_i
        |=> wb_err_o && !wb_ack_o && $stable(warn_trip_select))
        else $error("user write not refused");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    // Bit 5 is the enable and may read one; bits 6 and 4 to 2 may not
    rsvd_zero_a: assert property (warn_rd
        |-> (wb_dat_o & 32'hFFFF_FF5C) == 32'h0000_0000)
        else $error("reserved or ack bits read nonzero");
    trip_read_a: assert property (warn_rd |-> wb_dat_o[1:0] == warn_trip_select)
        else $error("trip select read-back differs");
    thresh_mix_a: assert property (
        warn_threshold == {detect_trip_select[0], warn_trip_select})
        else $error("threshold not formed from both selects");
    mon_off_a: assert property (monitor_enable == !low_power_mode)
        else $error("monitor enable wrong");
    trip_keep_a: assert property (chip_reset && !taken |=> $stable(warn_trip_select))
        else $error("chip reset changed trip select");
    chip_clear_a: assert property (chip_reset && !deep_stop_recovery |=> !warn_irq)
        else $error("chip reset left warning irq");
    ie_off_a: assert property (taken && wb_we_i && wb_tga_i && wb_sel_i[0]
        && !wb_dat_i[IE_BIT] && wb_adr_i[7:2] == WARN_IDX |=> !warn_irq)
        else $error("irq without enable");
    cover property (warn_rd && wb_dat_o[FLAG_BIT]);
    cover property (wb_err_o);
    cover property (warn_irq);
endmodule
bind low_voltage_warning_regs warn_checker warn_checker_i (.clk, .rst_b, .chip_reset,
    .deep_stop_recovery, .low_power_mode, .detect_trip_select, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_tga_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .warn_trip_select, .warn_threshold, .monitor_enable, .warn_irq);

// ### verification/low_voltage_warning_regs_tb_top.sv
/* Self-checking bench for the warning register block: random register traffic
   plus flag, interrupt, reset and low-power corner cases.
   Assumes the checker file is compiled alongside. */
module low_voltage_warning_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import warn_pkg::*;
    logic clk = 0, rst_b = 0, chip_reset = 0, deep_stop_recovery = 0, low_power_mode = 0;
    logic supply_below_warn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_tga_i = 0;
    logic [1:0]  detect_trip_select = 2'h0, warn_trip_select, tr_m;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, v;
    logic [2:0]  warn_threshold;
    logic        wb_ack_o, wb_err_o, monitor_enable, warn_irq, irq, got_err, t, ie_m, uw_m;
    int          error_cnt = 0, samples_checked = 0, seed = 29902;
    always #4 clk = ~clk;
    low_voltage_warning_regs low_voltage_warning_regs_i (.clk, .rst_b, .chip_reset,
        .deep_stop_recovery, .low_power_mode, .supply_below_warn, .detect_trip_select,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_tga_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .warn_trip_select, .warn_threshold,
        .monitor_enable, .warn_irq, .irq);
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] warn_exp(logic fl, logic en, logic [1:0] tp);
        return {24'h00_0000, fl, 1'b0, en, 3'h0, tp};
    endfunction
    // Holds the request until ack or err is sampled, then releases it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic g);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_tga_i <= g;
        // Waits as long as it takes; only the watchdog ends a hung cycle
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        // Answer is registered: seen at the second edge after the request
        chk("bus_answer", 32'h0000_0002, 32'(n));
        rd = wb_dat_o;
        got_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 1'b1);
        chk(n, e, rd);
    endtask
    task automatic tend(input string n);
        $display("test %s done", n);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rdc("warn_reset", 8'h04, warn_exp(0, 0, 2'h0));
        supply_below_warn <= 1'b1;
        repeat (6) @(posedge clk);
        rdc("flag_set", 8'h04, warn_exp(1, 0, 2'h0));
        wr(8'h04, 32'h0000_0000);
        rdc("flag_ro", 8'h04, warn_exp(1, 0, 2'h0));
        supply_below_warn <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h04, 32'h0000_0040);
        rdc("flag_clear", 8'h04, warn_exp(0, 0, 2'h0));
        // Supply edge timed so the detection lands on the edge that takes the clear
        supply_below_warn <= 1'b1;
        @(posedge clk);
        wr(8'h04, 32'h0000_0040);
        rdc("ack_vs_set", 8'h04, warn_exp(1, 0, 2'h0));
        supply_below_warn <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h04, 32'h0000_0040);
        tend("flag");
        {ie_m, tr_m, uw_m} = 4'h0;
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            t = 1'($random(seed));
            wb_sel_i <= 4'($random(seed));
            detect_trip_select <= 2'($random(seed));
            bus(1'b1, 8'h04, v, t);
            chk("user_err", 32'(!t), 32'(got_err));
            uw_m = uw_m | !t;
            if (t && wb_sel_i[0]) {ie_m, tr_m} = {v[5], v[1:0]};
            rdc("warn_rand", 8'h04, warn_exp(0, ie_m, tr_m));
            chk("trip_port", 32'(tr_m), 32'(warn_trip_select));
        end
        wb_sel_i <= 4'h1;
        rdc("unmapped", 8'h3C, 32'h0000_0000);
        tend("random");
        wr(8'h04, 32'h0000_0063);
        chk("irq_idle", 32'h0000_0000, 32'(warn_irq));
        supply_below_warn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("irq_on", 32'h0000_0001, 32'(warn_irq));
        wr(8'h10, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("evt_irq", 32'h0000_0001, 32'(irq));
        rdc("evt_stat", 8'h08, 32'({uw_m, 1'b1}));
        wr(8'h0C, 32'h0000_0003);
        rdc("evt_clr", 8'h08, 32'h0000_0000);
        chk("evt_irq_off", 32'h0000_0000, 32'(irq));
        wr(8'h04, 32'h0000_0063);
        repeat (2) @(posedge clk);
        chk("irq_off", 32'h0000_0000, 32'(warn_irq));
        tend("irq");
        chip_reset <= 1'b1;
        deep_stop_recovery <= 1'b1;
        @(posedge clk);
        chip_reset <= 1'b0;
        deep_stop_recovery <= 1'b0;
        rdc("deep_keep", 8'h04, warn_exp(0, 1, 2'h3));
        chip_reset <= 1'b1;
        @(posedge clk);
        chip_reset <= 1'b0;
        repeat (6) @(posedge clk);
        // Supply is still low, so the flag comes back after the reset
        rdc("chip_reset", 8'h04, warn_exp(1, 0, 2'h3));
        tend("chip_reset");
        wr(8'h04, 32'h0000_0043);
        supply_below_warn <= 1'b0;
        low_power_mode <= 1'b1;
        repeat (6) @(posedge clk);
        supply_below_warn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("mon_off", 32'h0000_0000, 32'(monitor_enable));
        rdc("lp_quiet", 8'h04, warn_exp(0, 0, 2'h3));
        low_power_mode <= 1'b0;
        repeat (6) @(posedge clk);
        rdc("lp_exit", 8'h04, warn_exp(1, 0, 2'h3));
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        rdc("por", 8'h04, warn_exp(1, 0, 2'h0));
        tend("reset");
        report_and_stop();
    end
endmodule
